// *** design/sgs_delay.sv ***
// Group 2 entry delay timer, counting whole milliseconds while run is high.
// Assumes run drops to restart; a zero delay expires on the first cycle of run.
`timescale 1ns/10ps
`include "sgs_map.svh"
module sgs_delay #(
    parameter int TICK_CYCLES = `SGS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Control
    input  wire logic        run,
    input  wire logic [15:0] delay_ms,
    output logic             done
);
    logic [31:0] tick_ff;
    logic [15:0] ms_ff;

    // Counters clear whenever run is low, so a cancelled wait starts over
    always_ff @(posedge clk) begin
        if (!resetn || !run) begin
            tick_ff <= 32'h0000_0000;
            ms_ff   <= 16'h0000;
        end else if (ms_ff != delay_ms) begin
            if (tick_ff == 32'(TICK_CYCLES - 1)) begin
                tick_ff <= 32'h0000_0000;
                ms_ff   <= ms_ff + 16'h0001;
            end else begin
                tick_ff <= tick_ff + 32'h0000_0001;
            end
        end
    end

    // Saturating compare: a delay shortened mid-wait to the elapsed count or below ends at once
    assign done = run && (ms_ff >= delay_ms);
endmodule : sgs_delay

// *** design/sgs_map.svh ***
// Address map, field positions, reset values and timing figures of the setting group selector.
// Assumes a 20 MHz core clock and a byte-addressed register port with 4-bit addresses.
`ifndef SGS_MAP_SVH
`define SGS_MAP_SVH

// Register byte addresses
`define SGS_ADDR_CFG      4'h0
`define SGS_ADDR_DELAY    4'h4
`define SGS_ADDR_SEL      4'h8
`define SGS_ADDR_STAT     4'hC

// Configuration register fields
`define SGS_CFG_COUNT_LSB 0
`define SGS_CFG_INV_BIT   4
`define SGS_CFG_ASG1_BIT  8
`define SGS_CFG_ASG2_BIT  9

// Status register fields
`define SGS_STAT_GRP_LSB  0
`define SGS_STAT_PEND_BIT 4
`define SGS_STAT_LVL_BIT  5
`define SGS_STAT_SHOW_BIT 6
`define SGS_STAT_REF_BIT  8

// Encodings of the group count and of the shared selection setting
`define SGS_COUNT_ONE     2'h1
`define SGS_COUNT_TWO     2'h2
`define SGS_SEL_G1        2'h1
`define SGS_SEL_G2        2'h2

// Reset values
`define SGS_RST_COUNT     2'h2
`define SGS_RST_INV       1'h0
`define SGS_RST_ASG       2'h3
`define SGS_RST_DELAY     16'h0064
`define SGS_RST_SEL       2'h1

// Timing: the entry delay is counted in milliseconds
`define SGS_CLK_NS        50
`define SGS_MS_NS         1000000
`define SGS_MS_CYCLES     (`SGS_MS_NS / `SGS_CLK_NS)
`define SGS_BOOT_CYC      2'h3

`endif

// *** design/sgs_pkg.sv ***
// Types shared by the setting group selector modules.
// Assumes the constants of sgs_map.svh are included where needed.
package sgs_pkg;

    // Selection state: power-up wait, group 1, group 1 with group 2 entry pending, group 2
    typedef enum logic [1:0] {
        SGS_ST_BOOT = 2'b00,
        SGS_ST_G1   = 2'b01,
        SGS_ST_WAIT = 2'b10,
        SGS_ST_G2   = 2'b11
    } sgs_state_t;

endpackage : sgs_pkg

// *** design/sgs_sync.sv ***
// Two-stage synchroniser for the group select binary input.
// Assumes the input is asynchronous to CLK; only the second stage is read.
`timescale 1ns/10ps
module sgs_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    // Pin and synchronised level
    input  wire logic pin_in,
    output logic      level_out
);
    logic meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!resetn) begin
            meta_ff   <= 1'b0;
            level_out <= 1'b0;
        end else begin
            meta_ff   <= pin_in;
            level_out <= meta_ff;
        end
    end
endmodule : sgs_sync

// *** design/sgs_top.sv ***
// Setting group selector: picks which of two protection parameter sets is active.
// Assumes a 20 MHz CLK, a synchronous active-low reset at power-up, an asynchronous
// group select pin and remote command pulses from logic on CLK.
//
// Operation
// - Exactly one of the two parameter sets is active at every moment.
// - The group count setting holds 1 for one set or 2 for two sets.
// - With a group count of one, group 1 is used whatever the input, panel or remote ask.
// - With one group the second set and the selection cell are hidden from the menu.
// - Switching is allowed at any time and each switch resets timers, flags, latches and outputs.
// - Under input control a low level selects group 1 and a high level holds group 2.
// - Input-driven entry into group 2 waits for the entry delay; return to group 1 is at once.
// - At power-up the group matches the current state of the assigned input.
// - A group 2 request from the input at power-up takes effect without the entry delay.
// - With inversion set, an energised input selects group 1 and a dead input group 2 after the delay.
// - While the input is assigned, its level decides and panel or remote changes are refused; assigned to one set only, its level is ignored.
// - Panel and remote share one selection setting, remote commands overwrite it and the group follows.
// - A remote change refused for priority is dropped, not kept for later.
// - The active group is readable and is offered as a signal for contacts and LEDs.
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
`include "sgs_map.svh"
module sgs_top #(
    parameter int TICK_CYCLES = `SGS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESETN,
    // Register port
    input  wire logic [3:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Group select binary input pin
    input  wire logic        GROUP_SEL_IN,
    // Remote group commands, one-cycle pulses
    input  wire logic        REMOTE_G1_CMD,
    input  wire logic        REMOTE_G2_CMD,
    // Active group and side effects
    output logic      [1:0]  ACTIVE_GROUP,
    output logic             ACTIVE_G2,
    output logic             PROT_RESET,
    output logic             MENU_SHOW_G2
);
    // Configuration and setting registers
    logic [1:0]  count_ff;
    logic        inv_ff;
    logic [1:0]  asg_ff;
    logic [15:0] delay_ff;
    logic [1:0]  sel_ff;
    logic        refused_ff;
    // Selection state
    sgs_pkg::sgs_state_t state_ff;
    sgs_pkg::sgs_state_t nxt_state;
    logic [1:0]  boot_cnt_ff;
    logic [1:0]  grp_ff;
    logic        act_g2_ff;
    logic        prot_reset_ff;
    logic        show_ff;
    logic [31:0] rdata_ff;
    // Decoded conditions
    logic        in_level;
    logic        two_grp;
    logic        in_ctrl;
    logic        in_valid;
    logic        in_req;
    logic        dly_run;
    logic        dly_done;
    logic        boot_done;
    logic        sel_allowed;
    logic        wr_cfg;
    logic        wr_delay;
    logic        wr_sel;
    logic        wr_stat;
    logic        panel_legal;
    logic        panel_g1;
    logic        panel_g2;
    logic        change_req;

    // Pin passes two flip-flops before anything looks at it
    sgs_sync u_sync (
        .clk       (CLK),
        .resetn    (RESETN),
        .pin_in    (GROUP_SEL_IN),
        .level_out (in_level)
    );

    // Entry delay runs only while a group 2 entry is pending
    sgs_delay #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_delay (
        .clk      (CLK),
        .resetn   (RESETN),
        .run      (dly_run),
        .delay_ms (delay_ff),
        .done     (dly_done)
    );

    // Write decode
    assign wr_cfg   = WR && (ADDR == `SGS_ADDR_CFG);
    assign wr_delay = WR && (ADDR == `SGS_ADDR_DELAY);
    assign wr_sel   = WR && (ADDR == `SGS_ADDR_SEL);
    assign wr_stat  = WR && (ADDR == `SGS_ADDR_STAT);

    // Input control state; the inversion option flips the requested sense
    assign two_grp   = (count_ff == `SGS_COUNT_TWO);
    assign in_ctrl   = |asg_ff;
    assign in_valid  = &asg_ff;
    assign in_req    = in_level ^ inv_ff;
    assign dly_run   = (state_ff == sgs_pkg::SGS_ST_WAIT);
    assign boot_done = (boot_cnt_ff == `SGS_BOOT_CYC);

    // Panel and remote may only steer the shared setting without input control
    assign sel_allowed = two_grp && !in_ctrl;
    assign panel_g1    = wr_sel && (WDATA[1:0] == `SGS_SEL_G1);
    assign panel_g2    = wr_sel && (WDATA[1:0] == `SGS_SEL_G2);
    assign panel_legal = panel_g1 || panel_g2;
    assign change_req  = panel_legal || REMOTE_G1_CMD || REMOTE_G2_CMD;

    // Group count accepts only 1 or 2; other codes leave it unchanged
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            count_ff <= `SGS_RST_COUNT;
            inv_ff   <= `SGS_RST_INV;
            asg_ff   <= `SGS_RST_ASG;
        end else if (wr_cfg) begin
            if (WDATA[`SGS_CFG_COUNT_LSB +: 2] == `SGS_COUNT_ONE ||
                WDATA[`SGS_CFG_COUNT_LSB +: 2] == `SGS_COUNT_TWO) begin
                count_ff <= WDATA[`SGS_CFG_COUNT_LSB +: 2];
            end
            inv_ff <= WDATA[`SGS_CFG_INV_BIT];
            asg_ff <= {WDATA[`SGS_CFG_ASG2_BIT], WDATA[`SGS_CFG_ASG1_BIT]};
        end
    end

    // Entry delay setting in milliseconds
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            delay_ff <= `SGS_RST_DELAY;
        end else if (wr_delay) begin
            delay_ff <= WDATA[15:0];
        end
    end

    // Shared selection setting; a remote command in the same cycle as a panel
    // write wins, and a refused request is simply not stored
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            sel_ff <= `SGS_RST_SEL;
        end else if (sel_allowed) begin
            if (REMOTE_G2_CMD) begin
                sel_ff <= `SGS_SEL_G2;
            end else if (REMOTE_G1_CMD) begin
                sel_ff <= `SGS_SEL_G1;
            end else if (panel_legal) begin
                sel_ff <= WDATA[1:0];
            end
        end
    end

    // Sticky refusal flag; a new refusal wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            refused_ff <= 1'b0;
        end else if (change_req && !sel_allowed) begin
            refused_ff <= 1'b1;
        end else if (wr_stat && WDATA[`SGS_STAT_REF_BIT]) begin
            refused_ff <= 1'b0;
        end
    end

    // Power-up wait covers the synchroniser latency before the pin is trusted
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            boot_cnt_ff <= 2'h0;
        end else if (!boot_done) begin
            boot_cnt_ff <= boot_cnt_ff + 2'h1;
        end
    end

    // Next group selection
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            sgs_pkg::SGS_ST_BOOT: begin
                if (boot_done) begin
                    if (!two_grp) begin
                        nxt_state = sgs_pkg::SGS_ST_G1;
                    end else if (in_ctrl) begin
                        if (in_valid && in_req) begin
                            nxt_state = sgs_pkg::SGS_ST_G2;
                        end else begin
                            nxt_state = sgs_pkg::SGS_ST_G1;
                        end
                    end else if (sel_ff == `SGS_SEL_G2) begin
                        nxt_state = sgs_pkg::SGS_ST_G2;
                    end else begin
                        nxt_state = sgs_pkg::SGS_ST_G1;
                    end
                end
            end
            sgs_pkg::SGS_ST_G1: begin
                if (!two_grp) begin
                    nxt_state = sgs_pkg::SGS_ST_G1;
                end else if (in_ctrl) begin
                    if (in_valid && in_req) begin
                        nxt_state = sgs_pkg::SGS_ST_WAIT;
                    end
                end else if (sel_ff == `SGS_SEL_G2) begin
                    nxt_state = sgs_pkg::SGS_ST_G2;
                end
            end
            sgs_pkg::SGS_ST_WAIT: begin
                if (!two_grp || !in_ctrl || !in_valid || !in_req) begin
                    nxt_state = sgs_pkg::SGS_ST_G1;
                end else if (dly_done) begin
                    nxt_state = sgs_pkg::SGS_ST_G2;
                end
            end
            sgs_pkg::SGS_ST_G2: begin
                if (!two_grp) begin
                    nxt_state = sgs_pkg::SGS_ST_G1;
                end else if (in_ctrl) begin
                    if (in_valid && !in_req) begin
                        nxt_state = sgs_pkg::SGS_ST_G1;
                    end
                end else if (sel_ff == `SGS_SEL_G1) begin
                    nxt_state = sgs_pkg::SGS_ST_G1;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            state_ff <= sgs_pkg::SGS_ST_BOOT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Active group outputs; group 1 stands through power-up so one set is always live
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            act_g2_ff <= 1'b0;
            grp_ff    <= `SGS_SEL_G1;
        end else begin
            act_g2_ff <= (nxt_state == sgs_pkg::SGS_ST_G2);
            grp_ff    <= (nxt_state == sgs_pkg::SGS_ST_G2) ? `SGS_SEL_G2 : `SGS_SEL_G1;
        end
    end

    // One-cycle reset of timers, flags and latches on every switch
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            prot_reset_ff <= 1'b0;
        end else begin
            prot_reset_ff <= ((nxt_state == sgs_pkg::SGS_ST_G2) != act_g2_ff);
        end
    end

    // Menu shows the second set and the selection cell only with two groups
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            show_ff <= 1'b0;
        end else begin
            show_ff <= two_grp;
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge CLK) begin
        if (!RESETN || !RD) begin
            rdata_ff <= 32'h0000_0000;
        end else begin
            unique case (ADDR)
                `SGS_ADDR_CFG: begin
                    rdata_ff <= {22'h00_0000, asg_ff, 3'h0, inv_ff, 2'h0, count_ff};
                end
                `SGS_ADDR_DELAY: begin
                    rdata_ff <= {16'h0000, delay_ff};
                end
                `SGS_ADDR_SEL: begin
                    rdata_ff <= {30'h0000_0000, sel_ff};
                end
                `SGS_ADDR_STAT: begin
                    rdata_ff <= {23'h00_0000, refused_ff, 1'h0, show_ff, in_level, dly_run,
                                 2'h0, grp_ff};
                end
                default: begin
                    rdata_ff <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign RDATA        = rdata_ff;
    assign ACTIVE_GROUP = grp_ff;
    assign ACTIVE_G2    = act_g2_ff;
    assign PROT_RESET   = prot_reset_ff;
    assign MENU_SHOW_G2 = show_ff;

    // Checks on the selection behaviour
    a_single_set: assert property (@(posedge CLK) disable iff (!RESETN)
        (grp_ff == `SGS_SEL_G1) || (grp_ff == `SGS_SEL_G2))
        else $error("active group is neither 1 nor 2");

    a_group_count: assert property (@(posedge CLK) disable iff (!RESETN)
        (count_ff == `SGS_COUNT_ONE) || (count_ff == `SGS_COUNT_TWO))
        else $error("group count holds an illegal value");

    a_one_group_g1: assert property (@(posedge CLK) disable iff (!RESETN)
        !two_grp |=> !act_g2_ff)
        else $error("group 2 active with one group configured");

    a_menu_hide: assert property (@(posedge CLK) disable iff (!RESETN)
        $past(RESETN) |-> (show_ff == $past(two_grp)))
        else $error("menu visibility does not follow group count");

    a_switch_reset: assert property (@(posedge CLK) disable iff (!RESETN)
        $changed(act_g2_ff) |-> prot_reset_ff)
        else $error("group switch without protection reset");

    a_entry_wait: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_ff == sgs_pkg::SGS_ST_G1 && two_grp && in_valid && in_req) |=> !act_g2_ff)
        else $error("group 2 entered without entry delay");

    a_return_instant: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_ff == sgs_pkg::SGS_ST_G2 && two_grp && in_valid && !in_req) |=> !act_g2_ff)
        else $error("return to group 1 not immediate");

    a_boot_immediate: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_ff == sgs_pkg::SGS_ST_BOOT && boot_done && two_grp && in_valid && in_req)
        |=> act_g2_ff)
        else $error("power-up group 2 delayed");

    a_panel_refused: assert property (@(posedge CLK) disable iff (!RESETN)
        (change_req && in_ctrl) |=> $stable(sel_ff) && refused_ff)
        else $error("change accepted under input control");

    a_remote_follow: assert property (@(posedge CLK) disable iff (!RESETN)
        (REMOTE_G2_CMD && sel_allowed && state_ff != sgs_pkg::SGS_ST_BOOT)
        |=> (sel_ff == `SGS_SEL_G2) ##1 act_g2_ff)
        else $error("remote group 2 command not followed");

    a_cancel_wait: assert property (@(posedge CLK) disable iff (!RESETN)
        (state_ff == sgs_pkg::SGS_ST_WAIT && !in_req) |=> (state_ff == sgs_pkg::SGS_ST_G1) && !act_g2_ff)
        else $error("pending switch not cancelled");

    a_status_match: assert property (@(posedge CLK) disable iff (!RESETN)
        act_g2_ff == (grp_ff == `SGS_SEL_G2))
        else $error("active group signal and status disagree");
endmodule : sgs_top

// *** sim/sgs_src_model.sv ***
// Behavioural model of the sources that feed the setting group selector: the group select pin and
// the remote command link. Assumes it shares CLK with the selector and is steered by bench tasks.
`timescale 1ns/10ps
module sgs_src_model (
    // Clock
    input  wire logic clk,
    // Sources toward the selector
    output logic      pin_lvl,
    output logic      rem_g1,
    output logic      rem_g2
);

    // Idle state: pin de-energised, no command on the link
    initial begin
        pin_lvl = 1'b0;
        rem_g1  = 1'b0;
        rem_g2  = 1'b0;
    end

    // Pin level is held until changed, as a contact would hold it
    task automatic set_pin(input logic v);
        @(posedge clk);
        pin_lvl <= v;
    endtask : set_pin

    // A remote command is one clock wide; a wider pulse could be taken twice
    task automatic remote(input logic to_g2);
        @(posedge clk);
        rem_g1 <= ~to_g2;
        rem_g2 <= to_g2;
        @(posedge clk);
        rem_g1 <= 1'b0;
        rem_g2 <= 1'b0;
    endtask : remote

endmodule : sgs_src_model

// *** sim/sgs_top_tb_top.sv ***
// Self-checking testbench of the setting group selector.
// Assumes sgs_top built with TICK_CYCLES of 4 and the source model of sgs_src_model.sv.
`timescale 1ns/10ps
`include "sgs_map.svh"
module sgs_top_tb_top;
    localparam int TICK = 4;
    logic        CLK;
    logic        RESETN;
    logic [3:0]  ADDR;
    logic [31:0] WDATA;
    logic        WR;
    logic        RD;
    logic [31:0] RDATA;
    logic        GROUP_SEL_IN;
    logic        REMOTE_G1_CMD;
    logic        REMOTE_G2_CMD;
    logic [1:0]  ACTIVE_GROUP;
    logic        ACTIVE_G2;
    logic        PROT_RESET;
    logic        MENU_SHOW_G2;
    int          mismatches;
    int          n_compared;
    int          cycles;
    int          n;
    logic [31:0] rv;

    // Block under test and its sources
    sgs_top #(.TICK_CYCLES(TICK)) DUT (
        .CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .GROUP_SEL_IN(GROUP_SEL_IN), .REMOTE_G1_CMD(REMOTE_G1_CMD), .REMOTE_G2_CMD(REMOTE_G2_CMD),
        .ACTIVE_GROUP(ACTIVE_GROUP), .ACTIVE_G2(ACTIVE_G2), .PROT_RESET(PROT_RESET),
        .MENU_SHOW_G2(MENU_SHOW_G2));
    sgs_src_model u_src (.clk(CLK), .pin_lvl(GROUP_SEL_IN), .rem_g1(REMOTE_G1_CMD), .rem_g2(REMOTE_G2_CMD));

    // 20 MHz clock
    initial begin
        CLK = 1'b0;
    end
    always #25 CLK = ~CLK;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge CLK) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Register port cycles; read data is taken in the one cycle it stands
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR    <= 1'b1;
        ADDR  <= a;
        WDATA <= d;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge CLK);
        RD   <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD   <= 1'b0;
        #1;
        d = RDATA;
    endtask : rd

    task automatic wait_g2(input logic v, input int max, output int k);
        k = max + 1;
        for (int i = 1; i <= max; i++) begin
            @(posedge CLK);
            #1;
            if (k > max && ACTIVE_G2 === v)
                k = i;
        end
    endtask : wait_g2

    // A switch must land inside [lo,hi] cycles with a one-cycle protection reset
    task automatic sw_check(input logic v, input int lo, input int hi, input string what);
        int k;
        k = 0;
        for (int i = 1; i <= hi && k == 0; i++) begin
            @(posedge CLK);
            #1;
            if (ACTIVE_G2 === v)
                k = i;
        end
        check(32'(k >= lo && k <= hi), 32'h1, what);
        check(32'(ACTIVE_GROUP), v ? 32'h2 : 32'h1, "group number");
        check(32'(PROT_RESET), 32'h1, "reset pulse");
        @(posedge CLK);
        #1;
        check(32'(PROT_RESET), 32'h0, "reset pulse end");
    endtask : sw_check

    // No switch and no protection reset for a number of cycles
    task automatic hold_check(input logic [1:0] g, input int cyc, input string what);
        int bad;
        bad = 0;
        repeat (cyc) begin
            @(posedge CLK);
            #1;
            if (ACTIVE_GROUP !== g || PROT_RESET !== 1'b0 || ACTIVE_G2 !== (g == 2'h2))
                bad++;
        end
        check(32'(bad), 32'h0, what);
    endtask : hold_check

    task automatic do_reset();
        @(posedge CLK);
        RESETN <= 1'b0;
        repeat (4) @(posedge CLK);
        RESETN <= 1'b1;
    endtask : do_reset

    task automatic t_reset_vals();
        hold_check(2'h1, 8, "power-up low pin");
        rd(`SGS_ADDR_CFG, rv);
        check(rv, 32'h0000_0302, "cfg reset");
        rd(`SGS_ADDR_DELAY, rv);
        check(rv, 32'h0000_0064, "delay reset");
        rd(`SGS_ADDR_SEL, rv);
        check(rv, 32'h0000_0001, "sel reset");
        rd(`SGS_ADDR_STAT, rv);
        check(rv, 32'h0000_0041, "status reset");
        @(posedge CLK);
        #1;
        check(RDATA, 32'h0, "read data gone");
        rd(4'h1, rv);
        check(rv, 32'h0, "unmapped read");
        check(32'(MENU_SHOW_G2), 32'h1, "menu shows set 2");
        $display("test reset_vals done");
    endtask : t_reset_vals

    task automatic t_input();
        wr(`SGS_ADDR_DELAY, 32'hFFFF_0003);
        rd(`SGS_ADDR_DELAY, rv);
        check(rv, 32'h0000_0003, "delay field only");
        u_src.set_pin(1'b1);
        sw_check(1'b1, 13, 20, "delayed entry");
        u_src.set_pin(1'b0);
        sw_check(1'b0, 1, 5, "instant return");
        u_src.set_pin(1'b1);
        hold_check(2'h1, 6, "pending entry");
        rd(`SGS_ADDR_STAT, rv);
        check(rv, 32'h0000_0071, "entry pending status");
        u_src.set_pin(1'b0);
        hold_check(2'h1, 20, "entry cancelled");
        u_src.set_pin(1'b1);
        sw_check(1'b1, 13, 20, "delay restarted");
        u_src.set_pin(1'b0);
        sw_check(1'b0, 1, 5, "return again");
        $display("test input done");
    endtask : t_input

    task automatic t_invert();
        wr(`SGS_ADDR_CFG, 32'h0000_FFFE);
        sw_check(1'b1, 12, 20, "dead pin entry");
        rd(`SGS_ADDR_CFG, rv);
        check(rv, 32'h0000_0312, "cfg reserved bits");
        u_src.set_pin(1'b1);
        sw_check(1'b0, 1, 5, "energised pin");
        u_src.set_pin(1'b0);
        sw_check(1'b1, 13, 20, "dead pin again");
        wr(`SGS_ADDR_CFG, 32'h0000_0303);
        sw_check(1'b0, 1, 5, "inversion off");
        rd(`SGS_ADDR_CFG, rv);
        check(rv, 32'h0000_0302, "illegal count kept");
        $display("test invert done");
    endtask : t_invert

    task automatic t_refuse();
        wr(`SGS_ADDR_SEL, 32'h2);
        rd(`SGS_ADDR_STAT, rv);
        check(32'(rv[8]), 32'h1, "panel refused");
        u_src.remote(1'b1);
        hold_check(2'h1, 10, "remote refused");
        wr(`SGS_ADDR_STAT, 32'h100);
        rd(`SGS_ADDR_STAT, rv);
        check(32'(rv[8]), 32'h0, "refusal cleared");
        wr(`SGS_ADDR_CFG, 32'h0000_0002);
        hold_check(2'h1, 10, "refused command dropped");
        u_src.remote(1'b1);
        sw_check(1'b1, 1, 3, "remote group 2");
        rd(`SGS_ADDR_SEL, rv);
        check(rv, 32'h2, "setting overwritten");
        u_src.remote(1'b0);
        sw_check(1'b0, 1, 3, "remote group 1");
        wr(`SGS_ADDR_SEL, 32'h2);
        sw_check(1'b1, 1, 3, "panel group 2");
        wr(`SGS_ADDR_SEL, 32'h1);
        sw_check(1'b0, 1, 3, "panel group 1");
        wr(`SGS_ADDR_SEL, 32'h3);
        rd(`SGS_ADDR_SEL, rv);
        check(rv, 32'h1, "illegal selection ignored");
        $display("test refuse done");
    endtask : t_refuse

    task automatic t_count1();
        u_src.remote(1'b1);
        sw_check(1'b1, 1, 3, "remote group 2");
        wr(`SGS_ADDR_CFG, 32'h0000_0001);
        sw_check(1'b0, 1, 3, "one group forces 1");
        check(32'(MENU_SHOW_G2), 32'h0, "menu hides set 2");
        u_src.remote(1'b1);
        wr(`SGS_ADDR_SEL, 32'h2);
        u_src.set_pin(1'b1);
        hold_check(2'h1, 20, "one group ignores all");
        u_src.set_pin(1'b0);
        wr(`SGS_ADDR_CFG, 32'h0000_0302);
        hold_check(2'h1, 8, "input control low");
        wr(`SGS_ADDR_CFG, 32'h0000_0102);
        u_src.set_pin(1'b1);
        hold_check(2'h1, 20, "single set assigned");
        $display("test count1 done");
    endtask : t_count1

    task automatic t_powerup();
        u_src.set_pin(1'b1);
        do_reset();
        wait_g2(1'b1, 10, n);
        check(32'(n <= 10), 32'h1, "power-up group 2 undelayed");
        check(32'(ACTIVE_GROUP), 32'h2, "power-up group number");
        $display("test powerup done");
    endtask : t_powerup

    // Main sequence
    initial begin
        mismatches    = 0;
        n_compared    = 0;
        cycles        = 0;
        RESETN        = 1'b0;
        ADDR          = 4'h0;
        WDATA         = 32'h0;
        WR            = 1'b0;
        RD            = 1'b0;
        do_reset();
        t_reset_vals();
        t_input();
        t_invert();
        t_refuse();
        t_count1();
        t_powerup();
        give_verdict();
    end

endmodule : sgs_top_tb_top
